// >>> hdl/lpfc_consts.vh
`ifndef LPFC_CONSTS_VH
`define LPFC_CONSTS_VH
// register indexes
`define LPFC_ADR_CTRL      3'h0
`define LPFC_ADR_SLEW      3'h1
`define LPFC_ADR_STAT      3'h2
`define LPFC_ADR_IEN       3'h3
`define LPFC_ADR_FLAGS     3'h4
`define LPFC_ADR_DRIVE     3'h5
// bit positions
`define LPFC_B_EN          7
`define LPFC_B_RXO         6
`define LPFC_B_WUE         3
`define LPFC_B_PUS         2
`define LPFC_B_SRC         0
`define LPFC_B_TDIS        7
`define LPFC_B_DT          7
`define LPFC_B_OC          6
`define LPFC_B_DRV         0
// reset values
`define LPFC_RST_SLEW      2'h0
`define LPFC_RST_BYTE      8'h00
// slew encodings
`define LPFC_SLEW_NORM     2'h0
`define LPFC_SLEW_SLOW     2'h1
`define LPFC_SLEW_FAST     2'h2
// mode codes
`define LPFC_M_SHUT        2'h0
`define LPFC_M_NORM        2'h1
`define LPFC_M_RXO         2'h2
`define LPFC_M_STBY        2'h3
// timing
`define LPFC_CLK_MHZ       50
`define LPFC_DT_LIM_US     1000
`define LPFC_OC_MASK_US    10
`define LPFC_WUF_US        100
`define LPFC_IRC_TICKS     2'h2
`define LPFC_BUS_CYCS      2'h2
`endif

// >>> hdl/lpfc_low_timer.v
`timescale 1ns/1ns
`default_nettype none
// counts cycles while run_in is high, saturates at LIMIT
module lpfc_low_timer #(
   parameter LIMIT = 500
) (
   input  wire        clk_in,
   input  wire        reset_n_in,
   input  wire        run_in,
   output reg         expired_out
);
   reg  [16:0] cnt_ff;
   wire [16:0] lim = LIMIT[16:0];

   always @(posedge clk_in) begin
      if (!reset_n_in) begin
         cnt_ff      <= 17'h00000;
         expired_out <= 1'b0;
      end else if (!run_in) begin
         cnt_ff      <= 17'h00000;
         expired_out <= 1'b0;
      end else begin
         if (cnt_ff != lim)
            cnt_ff <= cnt_ff + 17'h00001;
         expired_out <= (cnt_ff + 17'h00001 >= lim);
      end
   end
endmodule // lpfc_low_timer
`default_nettype wire

// >>> hdl/lpfc_refault.v
`timescale 1ns/1ns
`include "lpfc_consts.vh"
`default_nettype none
// delay after a flag clear: two rc ticks then two bus cycles
module lpfc_refault (
   input  wire        clk_in,
   input  wire        reset_n_in,
   input  wire        start_in,
   input  wire        irc_tick_in,
   output reg         done_out
);
   reg        busy_ff;
   reg  [1:0] tick_ff;
   reg  [1:0] cyc_ff;

   always @(posedge clk_in) begin
      if (!reset_n_in) begin
         busy_ff  <= 1'b0;
         tick_ff  <= 2'h0;
         cyc_ff   <= 2'h0;
         done_out <= 1'b0;
      end else begin
         done_out <= 1'b0;
         if (start_in) begin
            busy_ff <= 1'b1;
            tick_ff <= 2'h0;
            cyc_ff  <= 2'h0;
         end else if (busy_ff) begin
            // first tick may come at once, so two ticks give one full period
            if (tick_ff != `LPFC_IRC_TICKS) begin
               if (irc_tick_in)
                  tick_ff <= tick_ff + 2'h1;
            end else if (cyc_ff != `LPFC_BUS_CYCS - 2'h1) begin
               cyc_ff <= cyc_ff + 2'h1;
            end else begin
               busy_ff  <= 1'b0;
               done_out <= 1'b1;
            end
         end
      end
   end
endmodule // lpfc_refault
`default_nettype wire

// >>> hdl/lpfc_top.v
// Function
// - dominant timeout sets bit7, disables transmitter
// - write one clears flag, zero no effect
// - clear while input low: set again
// - overcurrent sets bit6, disables transmitter
// - clear while fault persists: set again
// - enabled flags merge into one request
// - transmit source: serial or direct drive
// - slew choices, reset to 20 kbit/s
// - timeout disable stops dominant protection
// - overcurrent inside mask window not reported
// - shutdown: no wake, no monitoring, registers open
// - enable goes to normal or receive-only
// - disable returns to shutdown
// - normal: rx and tx on, pull-up select
// - receive-only bit toggles normal/receive-only
// - receive-only: tx off, no monitoring
// - stop enters standby, exit restores mode
// - standby wake: long dominant then rise pulses
// - wake disabled forces weak pull-up
// - slew codes 00 norm, 01 slow, 10 fast
// - status bit shows input still dominant
// - re-set delay one to two rc periods
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ns
`include "lpfc_consts.vh"
`default_nettype none
module lpfc_top #(
   parameter DT_LIM_CYC = `LPFC_DT_LIM_US * `LPFC_CLK_MHZ,
   parameter WUF_CYC    = `LPFC_WUF_US * `LPFC_CLK_MHZ
) (
   input  wire        clk_in,
   input  wire        reset_n_in,
   input  wire [2:0]  addr_in,
   input  wire [7:0]  wdata_in,
   input  wire        wr_in,
   input  wire        rd_in,
   output reg  [7:0]  rdata_out,
   input  wire        sci_tx_in,
   input  wire        stop_mode_in,
   input  wire        overcurrent_in,
   input  wire        bus_level_in,
   input  wire        irc_tick_in,
   output reg         tx_enable_out,
   output reg         tx_level_out,
   output reg         rx_enable_out,
   output reg         rx_lowpower_out,
   output reg         pullup_strong_out,
   output reg  [1:0]  slew_out,
   output reg         receive_output_out,
   output reg         wake_pulse_out,
   output reg         irq_out,
   output reg  [1:0]  mode_out
);
   localparam OC_CYC = `LPFC_OC_MASK_US * `LPFC_CLK_MHZ;
   localparam [1:0] ST_SHUT = `LPFC_M_SHUT;
   localparam [1:0] ST_NORM = `LPFC_M_NORM;
   localparam [1:0] ST_RXO  = `LPFC_M_RXO;
   localparam [1:0] ST_STBY = `LPFC_M_STBY;

   function [0:0] w1c_next;
      input f;
      input set;
      input clr;
      begin
         w1c_next = (f & ~clr) | set;
      end
   endfunction

   // control and config
   reg        phy_enable_ff;
   reg        receive_only_select_ff;
   reg        wakeup_enable_ff;
   reg        pullup_select_ff;
   reg        tx_source_ff;
   reg        timeout_disable_ff;
   reg  [1:0] slew_rate_select_ff;
   reg        direct_drive_ff;
   reg        dominant_timeout_irq_enable_ff;
   reg        overcurrent_irq_enable_ff;
   // fault, mode and wake state
   reg        dominant_timeout_flag_ff;
   reg        overcurrent_flag_ff;
   reg        dominant_status_ff;
   reg        dt_lock_ff;
   reg        oc_lock_ff;
   reg  [1:0] mode_ff;
   reg        bus_prev_ff;
   reg        wake_armed_ff;

   reg  [1:0] nxt_mode;
   wire       wr_ctrl  = wr_in && (addr_in == `LPFC_ADR_CTRL);
   wire       wr_slew  = wr_in && (addr_in == `LPFC_ADR_SLEW);
   wire       wr_ien   = wr_in && (addr_in == `LPFC_ADR_IEN);
   wire       wr_flags = wr_in && (addr_in == `LPFC_ADR_FLAGS);
   wire       wr_drive = wr_in && (addr_in == `LPFC_ADR_DRIVE);

   wire tx_src = tx_source_ff ? direct_drive_ff : sci_tx_in;
   wire in_norm = (mode_ff == `LPFC_M_NORM);
   wire in_stby = (mode_ff == `LPFC_M_STBY);
   // monitoring only in normal mode and not disabled
   wire dt_mon = in_norm && !timeout_disable_ff;

   wire dt_expired;
   wire oc_window_over;
   wire wuf_expired;
   wire dt_retry_done;
   wire oc_retry_done;

   lpfc_low_timer #(.LIMIT(DT_LIM_CYC)) u_dt_timer (
      .clk_in      (clk_in),
      .reset_n_in  (reset_n_in),
      .run_in      (dt_mon && !tx_src),
      .expired_out (dt_expired)
   );

   lpfc_low_timer #(.LIMIT(OC_CYC)) u_oc_mask (
      .clk_in      (clk_in),
      .reset_n_in  (reset_n_in),
      .run_in      (in_norm && !tx_src),
      .expired_out (oc_window_over)
   );

   lpfc_low_timer #(.LIMIT(WUF_CYC)) u_wake_filt (
      .clk_in      (clk_in),
      .reset_n_in  (reset_n_in),
      .run_in      (in_stby && wakeup_enable_ff && !bus_level_in),
      .expired_out (wuf_expired)
   );

   wire dt_clr = wr_flags && wdata_in[`LPFC_B_DT];
   wire oc_clr = wr_flags && wdata_in[`LPFC_B_OC];
   // persistence judged while in normal mode only
   wire dt_persist = in_norm && (dominant_status_ff || !tx_src);
   wire oc_persist = in_norm && (overcurrent_in || !tx_src);

   lpfc_refault u_dt_retry (
      .clk_in      (clk_in),
      .reset_n_in  (reset_n_in),
      .start_in    (dt_clr && dt_lock_ff),
      .irc_tick_in (irc_tick_in),
      .done_out    (dt_retry_done)
   );

   lpfc_refault u_oc_retry (
      .clk_in      (clk_in),
      .reset_n_in  (reset_n_in),
      .start_in    (oc_clr && oc_lock_ff),
      .irc_tick_in (irc_tick_in),
      .done_out    (oc_retry_done)
   );

   // first expiry edge; the timer stays expired while low
   reg  dt_exp_prev_ff;
   wire dt_event = dt_expired && !dt_exp_prev_ff && dt_mon;
   wire dt_reset = dt_retry_done && dt_persist;
   wire tx_on    = in_norm && !dt_lock_ff && !oc_lock_ff;
   // events inside the mask window are only current-limited
   wire oc_event = overcurrent_in && tx_on && !tx_src && oc_window_over;
   wire oc_reset = oc_retry_done && oc_persist;

   always @* begin
      nxt_mode = mode_ff;
      case (mode_ff)
         ST_SHUT: begin
            // stop is only honoured from an enabled mode
            if (phy_enable_ff)
               nxt_mode = receive_only_select_ff ? ST_RXO : ST_NORM;
         end
         ST_NORM, ST_RXO: begin
            if (!phy_enable_ff)
               nxt_mode = ST_SHUT;
            else if (stop_mode_in)
               nxt_mode = ST_STBY;
            else if (receive_only_select_ff)
               nxt_mode = ST_RXO;
            else
               nxt_mode = ST_NORM;
         end
         ST_STBY: begin
            if (!phy_enable_ff)
               nxt_mode = ST_SHUT;
            else if (!stop_mode_in)
               nxt_mode = receive_only_select_ff ? ST_RXO : ST_NORM;
         end
         default: begin
            nxt_mode = ST_SHUT;
         end
      endcase
   end

   always @(posedge clk_in) begin
      if (!reset_n_in) begin
         phy_enable_ff                  <= 1'b0;
         receive_only_select_ff         <= 1'b0;
         wakeup_enable_ff               <= 1'b0;
         pullup_select_ff               <= 1'b0;
         tx_source_ff                   <= 1'b0;
         timeout_disable_ff             <= 1'b0;
         slew_rate_select_ff            <= `LPFC_RST_SLEW;
         direct_drive_ff                <= 1'b1;
         dominant_timeout_irq_enable_ff <= 1'b0;
         overcurrent_irq_enable_ff      <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            phy_enable_ff          <= wdata_in[`LPFC_B_EN];
            receive_only_select_ff <= wdata_in[`LPFC_B_RXO];
            wakeup_enable_ff       <= wdata_in[`LPFC_B_WUE];
            pullup_select_ff       <= wdata_in[`LPFC_B_PUS];
            tx_source_ff           <= wdata_in[`LPFC_B_SRC];
         end
         // writes ignored unless the layer is disabled
         if (wr_slew && !phy_enable_ff) begin
            timeout_disable_ff  <= wdata_in[`LPFC_B_TDIS];
            slew_rate_select_ff <= wdata_in[1:0];
         end
         if (wr_drive)
            direct_drive_ff <= wdata_in[`LPFC_B_DRV];
         if (wr_ien) begin
            dominant_timeout_irq_enable_ff <= wdata_in[`LPFC_B_DT];
            overcurrent_irq_enable_ff      <= wdata_in[`LPFC_B_OC];
         end
      end
   end

   always @(posedge clk_in) begin
      if (!reset_n_in) begin
         dominant_timeout_flag_ff <= 1'b0;
         overcurrent_flag_ff      <= 1'b0;
         dominant_status_ff       <= 1'b0;
         dt_lock_ff               <= 1'b0;
         oc_lock_ff               <= 1'b0;
         dt_exp_prev_ff           <= 1'b0;
         mode_ff                  <= `LPFC_M_SHUT;
      end else begin
         mode_ff        <= nxt_mode;
         dt_exp_prev_ff <= dt_expired;
         // set wins over a same-cycle clear
         dominant_timeout_flag_ff <= w1c_next(dominant_timeout_flag_ff,
                                             dt_event || dt_reset, dt_clr);
         overcurrent_flag_ff      <= w1c_next(overcurrent_flag_ff,
                                             oc_event || oc_reset, oc_clr);
         if (dt_event)
            dominant_status_ff <= 1'b1;
         else if (tx_src)
            dominant_status_ff <= 1'b0;
         // lock held until a retry finds the fault gone
         if (dt_event)
            dt_lock_ff <= 1'b1;
         else if (dt_retry_done && !dt_persist)
            dt_lock_ff <= 1'b0;
         if (oc_event)
            oc_lock_ff <= 1'b1;
         else if (oc_retry_done && !oc_persist)
            oc_lock_ff <= 1'b0;
      end
   end

   // wake detect: filtered dominant then rising edge
   always @(posedge clk_in) begin
      if (!reset_n_in) begin
         bus_prev_ff    <= 1'b1;
         wake_armed_ff  <= 1'b0;
         wake_pulse_out <= 1'b0;
      end else begin
         bus_prev_ff    <= bus_level_in;
         wake_pulse_out <= 1'b0;
         if (!in_stby || !wakeup_enable_ff) begin
            wake_armed_ff <= 1'b0;
         end else if (bus_level_in && !bus_prev_ff && (wake_armed_ff || wuf_expired)) begin
            // filter flag lags the release by a cycle, so the edge goes first
            wake_armed_ff  <= 1'b0;
            wake_pulse_out <= 1'b1;
         end else if (wuf_expired) begin
            wake_armed_ff <= 1'b1;
         end
      end
   end

   // link-side outputs, all registered
   always @(posedge clk_in) begin
      if (!reset_n_in) begin
         tx_enable_out      <= 1'b0;
         tx_level_out       <= 1'b1;
         rx_enable_out      <= 1'b0;
         rx_lowpower_out    <= 1'b0;
         pullup_strong_out  <= 1'b0;
         slew_out           <= `LPFC_RST_SLEW;
         receive_output_out <= 1'b1;
         irq_out            <= 1'b0;
         mode_out           <= `LPFC_M_SHUT;
      end else begin
         tx_enable_out   <= tx_on;
         // recessive whenever the driver is off
         tx_level_out    <= tx_on ? tx_src : 1'b1;
         rx_enable_out   <= in_norm || (mode_ff == `LPFC_M_RXO);
         rx_lowpower_out <= in_stby;
         pullup_strong_out <= (mode_ff != `LPFC_M_SHUT) && wakeup_enable_ff
                              && pullup_select_ff;
         slew_out        <= slew_rate_select_ff;
         receive_output_out <= (in_norm || mode_ff == `LPFC_M_RXO) ?
                               bus_level_in : 1'b1;
         irq_out <= (dominant_timeout_flag_ff && dominant_timeout_irq_enable_ff)
                 || (overcurrent_flag_ff && overcurrent_irq_enable_ff);
         mode_out <= mode_ff;
      end
   end

   // register reads, data one cycle after the strobe
   always @(posedge clk_in) begin
      if (!reset_n_in) begin
         rdata_out <= `LPFC_RST_BYTE;
      end else begin
         rdata_out <= `LPFC_RST_BYTE;
         if (rd_in) begin
            if (addr_in == `LPFC_ADR_CTRL) begin
               rdata_out[`LPFC_B_EN]  <= phy_enable_ff;
               rdata_out[`LPFC_B_RXO] <= receive_only_select_ff;
               rdata_out[`LPFC_B_WUE] <= wakeup_enable_ff;
               rdata_out[`LPFC_B_PUS] <= pullup_select_ff;
               rdata_out[`LPFC_B_SRC] <= tx_source_ff;
            end else if (addr_in == `LPFC_ADR_SLEW) begin
               rdata_out[`LPFC_B_TDIS] <= timeout_disable_ff;
               rdata_out[1:0]          <= slew_rate_select_ff;
            end else if (addr_in == `LPFC_ADR_STAT) begin
               rdata_out[`LPFC_B_DT] <= dominant_status_ff;
            end else if (addr_in == `LPFC_ADR_IEN) begin
               rdata_out[`LPFC_B_DT] <= dominant_timeout_irq_enable_ff;
               rdata_out[`LPFC_B_OC] <= overcurrent_irq_enable_ff;
            end else if (addr_in == `LPFC_ADR_FLAGS) begin
               rdata_out[`LPFC_B_DT] <= dominant_timeout_flag_ff;
               rdata_out[`LPFC_B_OC] <= overcurrent_flag_ff;
            end else if (addr_in == `LPFC_ADR_DRIVE) begin
               rdata_out[`LPFC_B_DRV] <= direct_drive_ff;
            end
         end
      end
   end
endmodule // lpfc_top
`default_nettype wire

// >>> tb/lpfc_line_model.sv
`timescale 1ns/1ns
`default_nettype none
// lin line with its pull-up, plus the free running rc oscillator
module lpfc_line_model (
   input  wire logic clk_in,
   input  wire logic tx_enable_in,
   input  wire logic tx_level_in,
   input  wire logic remote_low_in,
   output wire logic bus_level_out,
   output wire logic irc_tick_out
);
   int irc_cnt = 0;
   // pull-up wins unless our driver or another node pulls low
   assign bus_level_out = !((tx_enable_in && !tx_level_in) || remote_low_in);
   // one tick per 1 us at 50 MHz, phase unrelated to any request
   assign irc_tick_out = (irc_cnt == 49);
   always @(posedge clk_in) begin
      irc_cnt <= (irc_cnt == 49) ? 0 : irc_cnt + 1;
   end
endmodule // lpfc_line_model
`default_nettype wire

// >>> tb/lpfc_checker.sv
`timescale 1ns/1ns
`include "lpfc_consts.vh"
`default_nettype none
module lpfc_checker (
   input wire logic       clk_in,
   input wire logic       reset_n_in,
   input wire logic       rd_in,
   input wire logic [7:0] rdata_out,
   input wire logic [1:0] mode_out,
   input wire logic       tx_enable_out,
   input wire logic       tx_level_out,
   input wire logic       rx_enable_out,
   input wire logic       rx_lowpower_out,
   input wire logic       pullup_strong_out,
   input wire logic       receive_output_out,
   input wire logic       wake_pulse_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   // three cycles of a mode leave room for the output register lag
   rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
      else $error("read data not idle");
   shut_quiet_a: assert property ((mode_out == `LPFC_M_SHUT) [*3] |->
      !tx_enable_out && !rx_enable_out && !pullup_strong_out)
      else $error("driver active in shutdown");
   stby_low_a: assert property ((mode_out == `LPFC_M_STBY) [*3] |->
      rx_lowpower_out && !tx_enable_out)
      else $error("standby outputs wrong");
   rxo_txoff_a: assert property ((mode_out == `LPFC_M_RXO) [*3] |->
      !tx_enable_out && rx_enable_out)
      else $error("receive only outputs wrong");
   norm_rx_a: assert property ((mode_out == `LPFC_M_NORM) [*3] |->
      rx_enable_out && !rx_lowpower_out)
      else $error("normal mode receiver off");
   wake_once_a: assert property (wake_pulse_out |=> !wake_pulse_out)
      else $error("wake pulse too long");
   wake_stby_a: assert property (wake_pulse_out |-> $past(mode_out) == `LPFC_M_STBY)
      else $error("wake pulse outside standby");
   txoff_level_a: assert property (!tx_enable_out && $past(!tx_enable_out) |-> tx_level_out)
      else $error("dominant level while off");
   rxoff_recess_a: assert property (!rx_enable_out [*2] |-> receive_output_out)
      else $error("receive output not recessive");
endmodule // lpfc_checker
bind lpfc_top lpfc_checker lpfc_checker_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
   .rd_in(rd_in), .rdata_out(rdata_out), .mode_out(mode_out), .tx_enable_out(tx_enable_out),
   .tx_level_out(tx_level_out), .rx_enable_out(rx_enable_out),
   .rx_lowpower_out(rx_lowpower_out), .pullup_strong_out(pullup_strong_out),
   .receive_output_out(receive_output_out), .wake_pulse_out(wake_pulse_out));
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ns
`include "lpfc_consts.vh"
`default_nettype none
module tb_top;
   logic       clk_in, reset_n_in, wr_in, rd_in, sci_tx_in, stop_mode_in;
   logic       overcurrent_in, remote_low;
   logic [2:0] addr_in;
   logic [7:0] wdata_in;
   wire  [7:0] rdata_out;
   wire        bus_level_in, irc_tick_in, tx_enable_out, tx_level_out, rx_enable_out;
   wire        rx_lowpower_out, pullup_strong_out, receive_output_out, wake_pulse_out;
   wire        irq_out;
   wire  [1:0] slew_out, mode_out;
   int         n_errors, samples_checked, n_wake;
   // short counts keep the run brief
   lpfc_top #(.DT_LIM_CYC(40), .WUF_CYC(20)) lpfc_top_i (.clk_in(clk_in),
      .reset_n_in(reset_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
      .rd_in(rd_in), .rdata_out(rdata_out), .sci_tx_in(sci_tx_in),
      .stop_mode_in(stop_mode_in), .overcurrent_in(overcurrent_in),
      .bus_level_in(bus_level_in), .irc_tick_in(irc_tick_in), .tx_enable_out(tx_enable_out),
      .tx_level_out(tx_level_out), .rx_enable_out(rx_enable_out),
      .rx_lowpower_out(rx_lowpower_out), .pullup_strong_out(pullup_strong_out),
      .slew_out(slew_out), .receive_output_out(receive_output_out),
      .wake_pulse_out(wake_pulse_out), .irq_out(irq_out), .mode_out(mode_out));
   lpfc_line_model lpfc_line_model_i (.clk_in(clk_in), .tx_enable_in(tx_enable_out),
      .tx_level_in(tx_level_out), .remote_low_in(remote_low),
      .bus_level_out(bus_level_in), .irc_tick_out(irc_tick_in));
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   always @(posedge clk_in) if (wake_pulse_out === 1'b1) n_wake++;
   task automatic tally_and_finish;
      if (n_errors == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1;
      chk("rdata", rdata_out, exp);
   endtask
   task automatic s_reset;
      for (int i = 0; i < 7; i++) rd(3'(i), (i == 5) ? 8'h01 : 8'h00);
      chk("mode", 8'(mode_out), 8'(`LPFC_M_SHUT));
   endtask
   task automatic s_slew;
      for (int i = 0; i < 3; i++) begin
         wr(`LPFC_ADR_SLEW, 8'(i));
         rd(`LPFC_ADR_SLEW, 8'(i));
         chk("slew", 8'(slew_out), 8'(i));
      end
      wr(`LPFC_ADR_CTRL, 8'h80);
      wr(`LPFC_ADR_SLEW, 8'h01);
      rd(`LPFC_ADR_SLEW, 8'h02);
      wr(`LPFC_ADR_CTRL, 8'h00);
      wr(`LPFC_ADR_SLEW, 8'h00);
   endtask
   task automatic s_modes;
      @(posedge clk_in) sci_tx_in <= 1'b0;
      cyc(60);
      rd(`LPFC_ADR_FLAGS, 8'h00);
      @(posedge clk_in) sci_tx_in <= 1'b1;
      wr(`LPFC_ADR_CTRL, 8'h8c);
      cyc(3);
      chk("mode", 8'(mode_out), 8'(`LPFC_M_NORM));
      chk("trx", 8'({tx_enable_out, rx_enable_out, pullup_strong_out}), 8'h07);
      wr(`LPFC_ADR_CTRL, 8'h84);
      cyc(3);
      chk("pullup", 8'(pullup_strong_out), 8'h00);
      wr(`LPFC_ADR_CTRL, 8'hc4);
      cyc(3);
      chk("mode", 8'(mode_out), 8'(`LPFC_M_RXO));
      chk("trx", 8'({tx_enable_out, rx_enable_out}), 8'h01);
      @(posedge clk_in) sci_tx_in <= 1'b0;
      cyc(60);
      rd(`LPFC_ADR_FLAGS, 8'h00);
      @(posedge clk_in) sci_tx_in <= 1'b1;
      wr(`LPFC_ADR_CTRL, 8'h84);
      cyc(3);
      chk("mode", 8'(mode_out), 8'(`LPFC_M_NORM));
      @(posedge clk_in) stop_mode_in <= 1'b1;
      cyc(3);
      chk("mode", 8'(mode_out), 8'(`LPFC_M_STBY));
      @(posedge clk_in) stop_mode_in <= 1'b0;
      cyc(3);
      chk("mode", 8'(mode_out), 8'(`LPFC_M_NORM));
      wr(`LPFC_ADR_CTRL, 8'h00);
      cyc(3);
      chk("mode", 8'(mode_out), 8'(`LPFC_M_SHUT));
   endtask
   task automatic s_drive;
      wr(`LPFC_ADR_DRIVE, 8'h00);
      wr(`LPFC_ADR_CTRL, 8'h81);
      cyc(3);
      chk("level", 8'(tx_level_out), 8'h00);
      chk("rxd", 8'(receive_output_out), 8'h00);
      wr(`LPFC_ADR_DRIVE, 8'h01);
      cyc(3);
      chk("level", 8'(tx_level_out), 8'h01);
      chk("rxd", 8'(receive_output_out), 8'h01);
      wr(`LPFC_ADR_CTRL, 8'h00);
   endtask
   task automatic s_dt;
      wr(`LPFC_ADR_CTRL, 8'h80);
      wr(`LPFC_ADR_IEN, 8'h80);
      @(posedge clk_in) sci_tx_in <= 1'b0;
      cyc(50);
      chk("txen", 8'(tx_enable_out), 8'h00);
      chk("irq", 8'(irq_out), 8'h01);
      rd(`LPFC_ADR_STAT, 8'h80);
      rd(`LPFC_ADR_FLAGS, 8'h80);
      wr(`LPFC_ADR_FLAGS, 8'h00);
      rd(`LPFC_ADR_FLAGS, 8'h80);
      wr(`LPFC_ADR_FLAGS, 8'h80);
      cyc(40);
      rd(`LPFC_ADR_FLAGS, 8'h00);
      cyc(60);
      rd(`LPFC_ADR_FLAGS, 8'h80);
      wr(`LPFC_ADR_IEN, 8'h00);
      cyc(3);
      chk("irq", 8'(irq_out), 8'h00);
      @(posedge clk_in) sci_tx_in <= 1'b1;
      cyc(5);
      rd(`LPFC_ADR_STAT, 8'h00);
      wr(`LPFC_ADR_FLAGS, 8'h80);
      cyc(110);
      rd(`LPFC_ADR_FLAGS, 8'h00);
      chk("txen", 8'(tx_enable_out), 8'h01);
      wr(`LPFC_ADR_CTRL, 8'h00);
   endtask
   task automatic s_oc;
      wr(`LPFC_ADR_SLEW, 8'h80);
      wr(`LPFC_ADR_CTRL, 8'h80);
      wr(`LPFC_ADR_IEN, 8'h40);
      @(posedge clk_in) sci_tx_in <= 1'b0;
      cyc(100);
      @(posedge clk_in) overcurrent_in <= 1'b1;
      cyc(3);
      @(posedge clk_in) overcurrent_in <= 1'b0;
      cyc(3);
      chk("txen", 8'(tx_enable_out), 8'h01);
      cyc(450);
      rd(`LPFC_ADR_FLAGS, 8'h00);
      @(posedge clk_in) overcurrent_in <= 1'b1;
      cyc(3);
      chk("txen", 8'(tx_enable_out), 8'h00);
      chk("irq", 8'(irq_out), 8'h01);
      rd(`LPFC_ADR_FLAGS, 8'h40);
      wr(`LPFC_ADR_FLAGS, 8'h40);
      cyc(110);
      rd(`LPFC_ADR_FLAGS, 8'h40);
      @(posedge clk_in) begin
         overcurrent_in <= 1'b0;
         sci_tx_in <= 1'b1;
      end
      cyc(5);
      wr(`LPFC_ADR_FLAGS, 8'h40);
      cyc(110);
      rd(`LPFC_ADR_FLAGS, 8'h00);
      chk("txen", 8'(tx_enable_out), 8'h01);
      wr(`LPFC_ADR_CTRL, 8'h00);
      wr(`LPFC_ADR_SLEW, 8'h00);
      wr(`LPFC_ADR_IEN, 8'h00);
   endtask
   task automatic s_wake;
      for (int w = 1; w >= 0; w--) begin
         wr(`LPFC_ADR_CTRL, (w == 1) ? 8'h88 : 8'h80);
         @(posedge clk_in) stop_mode_in <= 1'b1;
         cyc(3);
         n_wake = 0;
         @(posedge clk_in) remote_low <= 1'b1;
         cyc(30);
         @(posedge clk_in) remote_low <= 1'b0;
         cyc(10);
         chk("wake", 8'(n_wake), 8'(w));
         @(posedge clk_in) stop_mode_in <= 1'b0;
         cyc(3);
      end
   endtask
   initial begin
      // bounded well above the fifteen hundred or so cycles the tests need
      #(20 * 20000);
      n_errors++;
      tally_and_finish;
   end
   initial begin
      reset_n_in = 1'b0;
      wr_in = 1'b0;
      rd_in = 1'b0;
      addr_in = 3'h0;
      wdata_in = 8'h00;
      sci_tx_in = 1'b1;
      stop_mode_in = 1'b0;
      overcurrent_in = 1'b0;
      remote_low = 1'b0;
      repeat (12) @(posedge clk_in);
      reset_n_in <= 1'b1;
      s_reset;
      s_slew;
      s_modes;
      s_drive;
      s_dt;
      s_oc;
      s_wake;
      tally_and_finish;
   end
endmodule // tb_top
`default_nettype wire
